/* File: logic/wkr_frame_rx.sv */
/*
   Wake radio receiver frame detector: line decoding, preamble lock,
   sync word hunt, payload and CRC collection, wake request.
   Assumes core_clk is the always-on slow clock and that the low-power
   state indication and flag clear come from logic on that clock.
*/
// What this block does
// - Decode on-off-keyed Manchester chips, Thomas polarity
// - Default 1 kbit/s bits, 2 kbit/s chips
// - Lock bit timing on long zero preamble
// - Exact 0x99 sync word before payload
// - Collect exactly 56 payload bits
// - Check 16-bit CRC over payload only
// - Runs on the always-on slow clock
// - Valid frame in deep sleep wakes chip
// - Keeps running in deep sleep when enabled
`timescale 1ns/1ps
`default_nettype none
`include "wkr_params.svh"
module wkr_frame_rx #(
   // chip period from the slow clock rate
   parameter int          CHIP_CYCLES   = `WKR_CLK_HZ / `WKR_CHIP_RATE_HZ,
   parameter int          MIN_LOCK_BITS = `WKR_MIN_LOCK_BITS,
   parameter logic [15:0] CRC_POLY      = `WKR_CRC_POLY,
   parameter logic [15:0] CRC_INIT      = `WKR_CRC_INIT
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         ook_data,
   input  wire logic         rx_enable,
   input  wire logic         deep_sleep,
   input  wire logic         flag_clear,
   output logic              wake_req,
   output logic              frame_flag,
   output logic              crc_error,
   output logic              rx_active,
   output wkr_pkg::wkr_payload_t payload
);
   import wkr_pkg::*;

   localparam logic [`WKR_ALT_W-1:0] LOCK_ALT =
      `WKR_ALT_W'(2 * MIN_LOCK_BITS - 1);
   localparam logic [`WKR_BITCNT_W-1:0] PAY_BITS =
      `WKR_BITCNT_W'(`WKR_PAYLOAD_BITS);
   localparam logic [`WKR_BITCNT_W-1:0] LAST_BIT =
      `WKR_BITCNT_W'(`WKR_FRAME_BITS - 1);

   wkr_rx_s r_reg;
   wkr_rx_s r_next;
   logic    chip_valid;
   logic    chip_value;
   logic    bit_val;
   logic    sync_hit;
   wkr_crc_t rx_crc_full;

   // ------------------------------------------------------------------
   // Chip recovery
   // ------------------------------------------------------------------
   // Mid-chip samples of the synchronised stream
   wkr_chip_sampler #(
      .CHIP_CYCLES (CHIP_CYCLES)
   ) u_sampler (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .ook_data   (ook_data),
      .rx_enable  (rx_enable),
      .chip_valid (chip_valid),
      .chip_value (chip_value)
   );

   // ------------------------------------------------------------------
   // Frame state machine
   // ------------------------------------------------------------------
   // Hunt for preamble and sync, then decode chip pairs into bits
   always_comb begin
      r_next = r_reg;
      r_next.wake = 1'b0;
      r_next.err = 1'b0;
      bit_val = r_reg.first_chip;
      // exact sync chip pattern after lock
      sync_hit = {r_reg.chip_sr[14:0], chip_value} == `WKR_SYNC_CHIPS &&
                 r_reg.since_lock <= `WKR_LOCK_WINDOW;
      rx_crc_full = {r_reg.rx_crc[`WKR_CRC_BITS-2:0], bit_val};
      // Software clear first so a new frame in the same cycle wins
      if (flag_clear) begin
         r_next.flag = 1'b0;
      end
      if (!rx_enable) begin
         r_next.state = WKR_HUNT;
         r_next.alt_cnt = '0;
         r_next.since_lock = `WKR_UNLOCKED;
         r_next.phase = 1'b0;
      end else if (chip_valid) begin
         case (r_reg.state)
            WKR_HUNT: begin
               r_next.chip_sr = {r_reg.chip_sr[14:0], chip_value};
               // count alternating chips of the zero preamble
               if (chip_value != r_reg.chip_sr[0]) begin
                  if (r_reg.alt_cnt != `WKR_ALT_MAX) begin
                     r_next.alt_cnt = r_reg.alt_cnt + 1'b1;
                  end
               end else begin
                  r_next.alt_cnt = '0;
               end
               if (r_reg.alt_cnt >= LOCK_ALT) begin
                  r_next.since_lock = '0;
               end else if (r_reg.since_lock != `WKR_UNLOCKED) begin
                  r_next.since_lock = r_reg.since_lock + 1'b1;
               end
               if (sync_hit) begin
                  r_next.state = WKR_PAYLOAD;
                  r_next.phase = 1'b0;
                  r_next.bit_cnt = '0;
                  r_next.crc = CRC_INIT;
               end
            end
            WKR_PAYLOAD: begin
               if (!r_reg.phase) begin
                  r_next.phase = 1'b1;
                  r_next.first_chip = chip_value;
               end else begin
                  r_next.phase = 1'b0;
                  // equal chip pair is a line code violation
                  if (r_reg.first_chip == chip_value) begin
                     r_next.state = WKR_HUNT;
                     r_next.alt_cnt = '0;
                     r_next.since_lock = `WKR_UNLOCKED;
                  end else begin
                     r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
                     if (r_reg.bit_cnt < PAY_BITS) begin
                        r_next.acc = {r_reg.acc[`WKR_PAYLOAD_BITS-2:0],
                                      bit_val};
                        r_next.crc = wkr_crc_step(r_reg.crc, bit_val,
                                                  CRC_POLY);
                     end else begin
                        r_next.rx_crc = rx_crc_full;
                     end
                     if (r_reg.bit_cnt == LAST_BIT) begin
                        r_next.state = WKR_HUNT;
                        r_next.alt_cnt = '0;
                        r_next.since_lock = `WKR_UNLOCKED;
                        if (rx_crc_full == r_reg.crc) begin
                           r_next.payload = r_reg.acc;
                           r_next.flag = 1'b1;
                           r_next.wake = deep_sleep;
                        end else begin
                           r_next.err = 1'b1;
                        end
                     end
                  end
               end
            end
            default: begin
               r_next.state = WKR_HUNT;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         // no lock until a preamble is seen
         r_reg.since_lock <= `WKR_UNLOCKED;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // All straight from state flops
   assign wake_req = r_reg.wake;
   assign frame_flag = r_reg.flag;
   assign crc_error = r_reg.err;
   assign rx_active = r_reg.state == WKR_PAYLOAD;
   assign payload = r_reg.payload;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   wake_in_sleep_a: assert property (
      wake_req |-> $past(deep_sleep) && frame_flag)
      else $error("wake request outside deep sleep");

   flag_held_a: assert property (
      frame_flag && !flag_clear |=> frame_flag)
      else $error("received-frame flag dropped without clear");

   flag_set_wins_a: assert property (
      $rose(frame_flag) || (frame_flag && $past(flag_clear))
      |-> $past(r_reg.state) == WKR_PAYLOAD && !crc_error)
      else $error("flag set without a good frame");

   payload_stable_a: assert property (
      $changed(payload) |-> frame_flag && $past(r_reg.bit_cnt) == LAST_BIT)
      else $error("payload changed outside frame end");

   crc_drop_a: assert property (
      crc_error |-> !wake_req && r_reg.state == WKR_HUNT &&
      $past(r_reg.bit_cnt) == LAST_BIT)
      else $error("bad frame not discarded");

   sync_entry_a: assert property (
      $rose(rx_active) |-> r_reg.chip_sr == `WKR_SYNC_CHIPS &&
      r_reg.bit_cnt == '0 && $past(r_reg.since_lock) <= `WKR_LOCK_WINDOW)
      else $error("payload entered without sync word");

   lock_needed_a: assert property (
      $rose(rx_active) |-> $past(r_reg.since_lock, 2) != `WKR_UNLOCKED)
      else $error("payload entered without preamble lock");

   frame_len_a: assert property (
      r_reg.bit_cnt <= LAST_BIT + 1'b1)
      else $error("frame bit count past frame length");

   bad_pair_a: assert property (
      rx_active && chip_valid && r_reg.phase &&
      chip_value == r_reg.first_chip |=> !rx_active && !crc_error &&
      !wake_req)
      else $error("line code violation not aborted");

   disabled_idle_a: assert property (
      !rx_enable |=> !rx_active ##1 !wake_req)
      else $error("receiver active while disabled");

   good_frame_c: cover property (wake_req);
   crc_fail_c: cover property (crc_error);
   sync_found_c: cover property ($rose(rx_active));
   clear_race_c: cover property (flag_clear && r_next.flag);

endmodule
`default_nettype wire

/* File: logic/wkr_params.svh */
/*
   Constants of the wake radio receiver: rates, frame layout, CRC setup,
   and state field widths.
   Assumes it is included by bare name from the wkr package and modules.
*/
`ifndef WKR_PARAMS_SVH
`define WKR_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and air rates
// ----------------------------------------------------------------------
`define WKR_CLK_HZ        40000000
`define WKR_BIT_RATE_HZ   1000
`define WKR_CHIP_RATE_HZ  (2 * `WKR_BIT_RATE_HZ)

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define WKR_PREAMBLE_BITS 40
`define WKR_SYNC_WORD     8'h99
// Sync word 1001_1001 after line coding, high-low for one, low-high for zero
`define WKR_SYNC_CHIPS    16'h9696
`define WKR_PAYLOAD_BITS  56
`define WKR_CRC_BITS      16
`define WKR_FRAME_BITS    (`WKR_PAYLOAD_BITS + `WKR_CRC_BITS)
`define WKR_MIN_LOCK_BITS 32

// ----------------------------------------------------------------------
// CRC setup
// ----------------------------------------------------------------------
`define WKR_CRC_POLY      16'h1021
`define WKR_CRC_INIT      16'hFFFF

// ----------------------------------------------------------------------
// State field widths and limits
// ----------------------------------------------------------------------
`define WKR_CNT_W         16
`define WKR_BITCNT_W      7
`define WKR_ALT_W         8
`define WKR_ALT_MAX       8'hFF
`define WKR_LOCK_W        5
`define WKR_LOCK_WINDOW   5'h10
`define WKR_UNLOCKED      5'h1F

`endif

/* File: logic/wkr_pkg.sv */
/*
   Types and helper functions of the wake radio receiver.
   Assumes wkr_params.svh is on the include path.
*/
`default_nettype none
package wkr_pkg;
`include "wkr_params.svh"

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef logic [`WKR_PAYLOAD_BITS-1:0] wkr_payload_t;
   typedef logic [`WKR_CRC_BITS-1:0]     wkr_crc_t;

   typedef enum logic [0:0] {
      WKR_HUNT,
      WKR_PAYLOAD
   } wkr_state_e;

   // Chip sampler state
   typedef struct packed {
      logic                  sync1;
      logic                  sync2;
      logic                  prev;
      logic [`WKR_CNT_W-1:0] cnt;
      logic                  chip_valid;
      logic                  chip_val;
   } wkr_smp_s;

   // Frame receiver state
   typedef struct packed {
      wkr_state_e               state;
      logic [15:0]              chip_sr;
      logic [`WKR_ALT_W-1:0]    alt_cnt;
      logic [`WKR_LOCK_W-1:0]   since_lock;
      logic                     phase;
      logic                     first_chip;
      logic [`WKR_BITCNT_W-1:0] bit_cnt;
      wkr_payload_t             acc;
      wkr_crc_t                 crc;
      wkr_crc_t                 rx_crc;
      wkr_payload_t             payload;
      logic                     flag;
      logic                     wake;
      logic                     err;
   } wkr_rx_s;

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   // One bit of a shift-left CRC, data fed MSB first
   function automatic wkr_crc_t wkr_crc_step(input wkr_crc_t crc,
                                             input logic     din,
                                             input wkr_crc_t poly);
      wkr_crc_t sh;
      sh = {crc[`WKR_CRC_BITS-2:0], 1'b0};
      return (crc[`WKR_CRC_BITS-1] ^ din) ? (sh ^ poly) : sh;
   endfunction

endpackage
`default_nettype wire

/* File: logic/wkr_chip_sampler.sv */
/*
   Chip sampler: synchronises the demodulated on-off-keyed stream and
   samples it at mid-chip, retiming its chip counter on every edge.
   Assumes the stream arrives asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wkr_params.svh"
module wkr_chip_sampler #(
   parameter int CHIP_CYCLES = `WKR_CLK_HZ / `WKR_CHIP_RATE_HZ
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic ook_data,
   input  wire logic rx_enable,
   output logic      chip_valid,
   output logic      chip_value
);
   import wkr_pkg::*;

   localparam logic [`WKR_CNT_W-1:0] HALF = `WKR_CNT_W'(CHIP_CYCLES / 2);
   localparam logic [`WKR_CNT_W-1:0] LAST = `WKR_CNT_W'(CHIP_CYCLES - 1);

   wkr_smp_s s_reg;
   wkr_smp_s s_next;
   logic     edge_seen;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Two-stage synchroniser, edge retiming and mid-chip sample
   always_comb begin
      s_next = s_reg;
      s_next.sync1 = ook_data;
      s_next.sync2 = s_reg.sync1;
      s_next.prev = s_reg.sync2;
      s_next.chip_valid = 1'b0;
      edge_seen = s_reg.sync2 != s_reg.prev;
      if (!rx_enable) begin
         s_next.cnt = '0;
      end else if (edge_seen || s_reg.cnt == LAST) begin
         s_next.cnt = '0;
      end else begin
         s_next.cnt = s_reg.cnt + 1'b1;
      end
      if (rx_enable && !edge_seen && s_reg.cnt == HALF) begin
         s_next.chip_valid = 1'b1;
         s_next.chip_val = s_reg.sync2;
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign chip_valid = s_reg.chip_valid;
   assign chip_value = s_reg.chip_val;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chip_mid_point_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      chip_valid |-> $past(s_reg.cnt) == HALF && $past(rx_enable))
      else $error("chip sampled away from mid-chip");

   sample_cover_c: cover property (
      @(posedge core_clk) disable iff (!rst_n) chip_valid);

endmodule
`default_nettype wire

/* File: testbench/wkr_tx_model.sv */
/*
   Remote transmitter model: sends one wake-up frame on ook_data for
   each send pulse, with a chosen preamble length, sync word and CRC,
   or cut off with the carrier lost after the first payload byte.
   Assumes core_clk comes from the bench; the line rests low (no
   carrier) between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module wkr_tx_model #(
   parameter int CHIP_CYCLES = 16
) (
   input  wire logic                   core_clk,
   input  wire logic                   send,
   input  wire logic                   bad_crc,
   input  wire logic                   cut,
   input  wire logic [7:0]             sync_word,
   input  wire logic [5:0]             pre_bits,
   input  wire wkr_pkg::wkr_payload_t  frame_payload,
   output logic                        busy,
   output logic                        ook_data
);
   import wkr_pkg::*;

   logic [15:0] crc_val;

   // Payload CRC, worked out apart from the receiver
   function automatic logic [15:0] crc_of(input wkr_payload_t d);
      logic [15:0] c;
      c = 16'hFFFF;
      for (int i = 55; i >= 0; i--) begin
         c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
      return c;
   endfunction

   task automatic send_bit(input logic b);
      ook_data <= b;
      repeat (CHIP_CYCLES) @(posedge core_clk);
      ook_data <= ~b;
      repeat (CHIP_CYCLES) @(posedge core_clk);
   endtask

   // Idle line low, then one frame per send, all fields MSB first
   initial begin
      busy = 1'b0;
      ook_data = 1'b0;
      forever begin
         @(posedge core_clk);
         while (send !== 1'b1) @(posedge core_clk);
         busy <= 1'b1;
         crc_val = crc_of(frame_payload) ^ {15'h0000, bad_crc};
         for (int i = 0; i < pre_bits; i++) send_bit(1'b0);
         for (int i = 7; i >= 0; i--) send_bit(sync_word[i]);
         // payload bits, only the first byte when cut
         for (int i = 55; i >= (cut ? 48 : 0); i--) begin
            send_bit(frame_payload[i]);
         end
         if (cut) begin
            // carrier lost, idle chips form an equal pair
            ook_data <= 1'b0;
            repeat (4 * CHIP_CYCLES) @(posedge core_clk);
         end else begin
            for (int i = 15; i >= 0; i--) send_bit(crc_val[i]);
         end
         ook_data <= 1'b0;
         busy <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/wakeup_frame_receiver_test.sv */
/*
   Self-checking bench of the wake radio receiver frame detector.
   Assumes the transmitter model is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module wakeup_frame_receiver_test;
   import wkr_pkg::*;

   localparam int           CHIP = 16;
   localparam wkr_payload_t P1   = 56'hA5C3_0F96_1E2D_B7;
   localparam wkr_payload_t P2   = 56'h8000_0000_0000_01;
   localparam wkr_payload_t P3   = 56'hFFFF_0000_FFFF_00;

   logic         core_clk, rst_n, rx_enable, deep_sleep, flag_clear;
   logic         send, bad_crc, busy, ook_data, cut;
   logic         wake_req, frame_flag, crc_error, rx_active;
   logic [7:0]   sync_word;
   logic [5:0]   pre_bits;
   wkr_payload_t payload, tx_payload;
   int           n_errors = 0, n_tests = 0;
   int           n_wake = 0, n_crc = 0, n_act = 0, n_flag = 0;
   int           d_wake, d_crc, d_act, d_flag;

   // ------------------------------------------------------------------
   // Clock, design and transmitter
   // ------------------------------------------------------------------
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   wkr_frame_rx #(.CHIP_CYCLES(CHIP)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .ook_data(ook_data),
      .rx_enable(rx_enable), .deep_sleep(deep_sleep),
      .flag_clear(flag_clear), .wake_req(wake_req),
      .frame_flag(frame_flag), .crc_error(crc_error),
      .rx_active(rx_active), .payload(payload));

   wkr_tx_model #(.CHIP_CYCLES(CHIP)) tx (
      .core_clk(core_clk), .send(send), .bad_crc(bad_crc), .cut(cut),
      .sync_word(sync_word), .pre_bits(pre_bits),
      .frame_payload(tx_payload), .busy(busy), .ook_data(ook_data));

   // Pulse and activity counters
   always @(posedge core_clk) begin
      if (wake_req === 1'b1) n_wake++;
      if (crc_error === 1'b1) n_crc++;
      if (rx_active === 1'b1) n_act++;
      if (frame_flag === 1'b1) n_flag++;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   // Send one frame, wait for its end, collect pulse counts
   task automatic run_frame(input wkr_payload_t p, input logic [7:0] s,
                            input logic [5:0] pb, input logic bad);
      int w0, c0, a0, f0, k;
      w0 = n_wake;
      f0 = n_flag;
      c0 = n_crc;
      a0 = n_act;
      tx_payload <= p;
      sync_word <= s;
      pre_bits <= pb;
      bad_crc <= bad;
      send <= 1'b1;
      @(posedge core_clk);
      send <= 1'b0;
      @(posedge core_clk);
      k = 0;
      while (busy === 1'b1 && k < 5000) begin
         @(posedge core_clk);
         k++;
      end
      check(k < 5000, 1, "frame did not end");
      repeat (20) @(posedge core_clk);
      d_wake = n_wake - w0;
      d_crc = n_crc - c0;
      d_act = n_act - a0;
      d_flag = n_flag - f0;
   endtask

   task automatic pulse_clear;
      flag_clear <= 1'b1;
      @(posedge core_clk);
      flag_clear <= 1'b0;
      repeat (2) @(posedge core_clk);
      check(frame_flag, 1'b0, "flag not cleared");
   endtask

   task automatic wrap_up;
      $display("Comparisons: %0d  mismatches: %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset;
      check({wake_req, frame_flag, crc_error, rx_active}, 4'h0, "outs");
      check(payload, 56'h0, "payload after reset");
      $display("test reset done");
   endtask

   task automatic t_good_sleep;
      deep_sleep <= 1'b1;
      run_frame(P1, 8'h99, 6'd40, 1'b0);
      check(d_wake, 1, "wake pulses in deep sleep");
      check(d_crc, 0, "crc error on good frame");
      check(d_act, 72 * 2 * CHIP, "collection span");
      check(frame_flag, 1'b1, "flag not set");
      check(payload, P1, "payload");
      $display("test good frame in deep sleep done");
   endtask

   task automatic t_awake;
      pulse_clear();
      deep_sleep <= 1'b0;
      run_frame(P2, 8'h99, 6'd40, 1'b0);
      check(d_wake, 0, "wake while awake");
      check(frame_flag, 1'b1, "flag not set");
      check(payload, P2, "payload");
      $display("test good frame while awake done");
   endtask

   task automatic t_bad_crc;
      pulse_clear();
      deep_sleep <= 1'b1;
      run_frame(P3, 8'h99, 6'd40, 1'b1);
      check(d_crc, 1, "crc error pulses");
      check(d_wake, 0, "wake on bad frame");
      check(frame_flag, 1'b0, "flag on bad frame");
      check(payload, P2, "payload overwritten");
      run_frame(P3, 8'h99, 6'd40, 1'b0);
      check(d_wake, 1, "wake after bad frame");
      check(payload, P3, "payload after bad frame");
      $display("test bad crc then good frame done");
   endtask

   task automatic t_bad_sync;
      pulse_clear();
      run_frame(P1, 8'h98, 6'd40, 1'b0);
      check(d_act, 0, "collection on wrong sync");
      check(frame_flag, 1'b0, "flag on wrong sync");
      check(payload, P3, "payload on wrong sync");
      $display("test wrong sync done");
   endtask

   task automatic t_short_pre;
      repeat (600) @(posedge core_clk);
      run_frame(P1, 8'h99, 6'd8, 1'b0);
      check(d_act, 0, "collection on short preamble");
      check(payload, P3, "payload on short preamble");
      $display("test short preamble done");
   endtask

   task automatic t_disabled;
      rx_enable <= 1'b0;
      run_frame(P1, 8'h99, 6'd40, 1'b0);
      check(d_act + d_wake, 0, "activity while disabled");
      check(frame_flag, 1'b0, "flag while disabled");
      rx_enable <= 1'b1;
      $display("test disabled receiver done");
   endtask

   task automatic t_cut_frame;
      cut <= 1'b1;
      run_frame(P1, 8'h99, 6'd40, 1'b0);
      cut <= 1'b0;
      check(d_act, (8 * 2 + 2) * CHIP, "span of cut frame");
      check(rx_active, 1'b0, "still collecting after cut");
      check(d_crc, 0, "crc error on cut frame");
      check(d_wake, 0, "wake on cut frame");
      check(frame_flag, 1'b0, "flag on cut frame");
      check(payload, P3, "payload on cut frame");
      $display("test cut frame done");
   endtask

   task automatic t_clear_race;
      flag_clear <= 1'b1;
      run_frame(P1, 8'h99, 6'd40, 1'b0);
      flag_clear <= 1'b0;
      check(d_flag, 1, "flag cycles under clear");
      check(frame_flag, 1'b0, "flag after clear");
      check(payload, P1, "payload under clear");
      $display("test clear against frame end done");
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      rx_enable = 1'b1;
      deep_sleep = 1'b0;
      flag_clear = 1'b0;
      send = 1'b0;
      bad_crc = 1'b0;
      cut = 1'b0;
      sync_word = 8'h99;
      pre_bits = 6'd40;
      tx_payload = '0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_good_sleep();
      t_awake();
      t_bad_crc();
      t_bad_sync();
      t_short_pre();
      t_cut_frame();
      t_disabled();
      t_clear_race();
      wrap_up();
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      $display("[FAIL] %0t ns watchdog expired", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
